// *** dv/scc_board_model.sv ***
// Board strap resistors and system reset source facing the strap block.
`timescale 1ns/1ps
`default_nettype none
module scc_board_model #(
	parameter logic [2:0] DLL_TICK = 3'h2
) (
	input wire logic rstDriveN,
	input wire logic systemResetOutputN,
	input wire scc_pkg::scc_straps_t boardStraps,
	output logic systemResetInputN,
	output scc_pkg::scc_straps_t memoryDataStrapLines
);
	import scc_pkg::*;
	scc_straps_t heldStraps;

	// The board may move its straps only while reset is asserted or once the output is released.
	// Between the two the last level stays on the lines, so early freezing is not masked.
	always_latch begin
		if (!rstDriveN || systemResetOutputN) begin
			heldStraps = boardStraps;
			heldStraps[43:41] = DLL_TICK;
		end
	end

	// The reset pin follows the bench's request directly.
	assign systemResetInputN = rstDriveN;
	assign memoryDataStrapLines = heldStraps;
endmodule : scc_board_model
`default_nettype wire

// *** dv/tb_scc_strap_clock_config.sv ***
// Self-checking testbench for the strap clock configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_scc_strap_clock_config;
	import scc_pkg::*;
	logic core_clk, reset_n, clkEn, rstDriveN, systemResetInputN, clocksSameFreq;
	logic avs_read, avs_write, avs_waitrequest, systemResetOutputN;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [1:0] avs_response, r;
	logic dotClockOeN, memoryClockOeN, hostClockOeN, unifyClocks, hostInputPllEn;
	logic coreTimesTwoMode, localBusEn, isaBusEn;
	scc_range_e pciClockRange, hostInputRange;
	scc_pcidiv_e pciClockDivisor;
	logic [4:0] hostSynthCode;
	logic [2:0] coreDllTick, b;
	scc_straps_t boardStraps, memoryDataStrapLines, s;
	logic [7:0] e4a, e4c, e5f;
	logic [11:0] est;
	logic [21:0] eOut;
	logic [4:0] codeTab [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h13, 5'h1f, 5'h00};
	int error_cnt, compares, n;

	scc_strap_clock_config u_scc_strap_clock_config (.core_clk(core_clk), .reset_n(reset_n),
		.clkEn(clkEn), .systemResetInputN(systemResetInputN),
		.memoryDataStrapLines(memoryDataStrapLines), .clocksSameFreq(clocksSameFreq),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .systemResetOutputN(systemResetOutputN),
		.dotClockOeN(dotClockOeN), .memoryClockOeN(memoryClockOeN), .hostClockOeN(hostClockOeN),
		.pciClockRange(pciClockRange), .pciClockDivisor(pciClockDivisor),
		.unifyClocks(unifyClocks), .hostSynthCode(hostSynthCode), .hostInputRange(hostInputRange),
		.hostInputPllEn(hostInputPllEn), .coreTimesTwoMode(coreTimesTwoMode),
		.coreDllTick(coreDllTick), .localBusEn(localBusEn), .isaBusEn(isaBusEn));

	scc_board_model u_scc_board_model (.rstDriveN(rstDriveN), .systemResetOutputN(systemResetOutputN),
		.boardStraps(boardStraps), .systemResetInputN(systemResetInputN),
		.memoryDataStrapLines(memoryDataStrapLines));

	// Free-running core clock at 40 MHz.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon transfer; the request holds until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		q = avs_readdata;
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk({31'h0, avs_waitrequest}, 32'h0);
	endtask : bus

	task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask : rdchk

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// A hang is cut well past the roughly eleven hundred cycles the sequence needs.
	initial begin
		#500000;
		error_cnt++;
		$display("mismatch at %0t: got %h expected %h", $time, 32'h0, 32'h1);
		tally_and_finish();
	end

	// Each pass samples a fresh strap set, releases reset and checks every register and pin.
	initial begin
		error_cnt = 0;
		compares = 0;
		reset_n = 1'b0;
		clkEn = 1'b1;
		rstDriveN = 1'b0;
		clocksSameFreq = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 10'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		boardStraps = '0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			b = i[2:0];
			s = {49{b[0]}};
			s[7:6] = b[1:0];
			s[5] = b[0];
			s[4] = b[1];
			s[17] = b[2] ^ b[0];
			{s[3:2], s[26:24]} = codeTab[i];
			s[20:18] = b;
			s[40] = b[1];
			s[43:41] = 3'h2;
			s[44] = b[0];
			s[46:45] = b[2:1];
			e4a = {s[7:6], s[5], s[4], s[3:2], 2'h0};
			e4c = {3'h0, s[20:17], 1'h0};
			e5f = {s[3:2], s[26:24], 3'h0};
			est = {s[5] & b[2], s[46:45] == 2'h3, s[7:6] == 2'h3, {s[4], s[17]} == 2'h0,
				s[43:41], s[46:45], s[40], s[44], 1'b1};
			eOut = {~s[20], ~s[19], ~s[18], s[7:6], s[4], s[17], s[5] & b[2], s[3:2], s[26:24],
				s[46:45], s[46:45] != 2'h3, s[40], s[43:41], s[44], ~s[44]};
			// Wrong levels first, then the real ones, both while the reset input is low.
			@(posedge core_clk);
			rstDriveN <= 1'b0;
			boardStraps <= ~s;
			clocksSameFreq <= b[2];
			repeat (12) @(posedge core_clk);
			chk({31'h0, systemResetOutputN}, 32'h0);
			boardStraps <= s;
			repeat (12) @(posedge core_clk);
			rstDriveN <= 1'b1;
			n = 0;
			while (systemResetOutputN !== 1'b1 && n < 200) begin
				@(posedge core_clk);
				n++;
			end
			chk({31'h0, n >= 40 && n < 60}, 32'h1);
			// The board is free again; the captured set must not follow it.
			boardStraps <= ~s;
			repeat (12) @(posedge core_clk);
			@(negedge core_clk);
			chk({10'h0, dotClockOeN, memoryClockOeN, hostClockOeN, pciClockRange,
				pciClockDivisor, unifyClocks, hostSynthCode, hostInputRange, hostInputPllEn,
				coreTimesTwoMode, coreDllTick, localBusEn, isaBusEn}, {10'h0, eOut});
			rdchk(10'h128, {24'h0, e4a}, 2'h0);
			rdchk(10'h12c, 32'h0, 2'h0);
			rdchk(10'h130, {24'h0, e4c}, 2'h0);
			rdchk(10'h17c, {24'h0, e5f}, 2'h0);
			rdchk(10'h180, {20'h0, est}, 2'h0);
			rdchk(10'h200, 32'h0, 2'h3);
			rdchk(10'h129, 32'h0, 2'h3);
			bus(1'b1, 10'h128, {24'h0, ~e4a});
			chk({30'h0, r}, 32'h0);
			rdchk(10'h128, {24'h0, e4a}, 2'h0);
			bus(1'b1, 10'h200, 32'hff);
			chk({30'h0, r}, 32'h3);
			bus(1'b1, 10'h130, {24'h0, ~e4c});
			rdchk(10'h130, {24'h0, e4c ^ 8'h10}, 2'h0);
			@(negedge core_clk);
			chk({29'h0, dotClockOeN, memoryClockOeN, hostClockOeN}, {29'h0, s[20], ~s[19:18]});
			// A low clock enable freezes the synchroniser, so a new reset request stays unseen.
			@(posedge core_clk);
			clkEn <= 1'b0;
			rstDriveN <= 1'b0;
			repeat (12) @(posedge core_clk);
			chk({31'h0, systemResetOutputN}, 32'h1);
			clkEn <= 1'b1;
		end
		tally_and_finish();
	end
endmodule : tb_scc_strap_clock_config
`default_nettype wire

// *** verilog/scc_defines.svh ***
// Named constants for the strap clock configuration block.
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// Register indices; the bus byte address is four times the index.
`define SCC_IDX_PCI_SYNC 8'h4a
`define SCC_IDX_RSVD 8'h4b
`define SCC_IDX_PAD_DIR 8'h4c
`define SCC_IDX_HOST_SPD 8'h5f
`define SCC_IDX_STATUS 8'h60
`define SCC_ADDR_W 10
`define SCC_IDX_RANGE 9:2
`define SCC_ALIGN_RANGE 1:0

// Strap line positions.
`define SCC_MD_W 49
`define SCC_MD_PCI_RANGE 7:6
`define SCC_MD_SYNC 5
`define SCC_MD_PCI_DIV_HI 4
`define SCC_MD_HOST_SPD_HI 3:2
`define SCC_MD_PCI_DIV_LO 17
`define SCC_MD_HOST_PAD 18
`define SCC_MD_MEM_PAD 19
`define SCC_MD_DOT_PAD 20
`define SCC_MD_HOST_SPD_LO 26:24
`define SCC_MD_CORE_X2 40
`define SCC_MD_DLL_TICK 43:41
`define SCC_MD_BUS_SEL 44
`define SCC_MD_HOST_CLOCK_INPUT_RANGE 46:45

// Register field positions.
`define SCC_S2_DOT_BIT 4
`define SCC_RESERVED_CODE 2'h3
`define SCC_BYTE0_BE 0

// Avalon response codes.
`define SCC_RESP_OKAY 2'h0
`define SCC_RESP_DECODEERR 2'h3

// Delay from reset input release to reset output release.
`define SCC_CLK_PERIOD_NS 25
`define SCC_RELEASE_TIME_NS 1000
`define SCC_RELEASE_CYCLES ((`SCC_RELEASE_TIME_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_HOLD_CNT_W 6

`endif

// *** verilog/scc_pkg.sv ***
// Types shared by the strap clock configuration block.
package scc_pkg;
	`include "scc_defines.svh"

	// Clock range selection carried by two straps.
	typedef enum logic [1:0] {
		SCC_RANGE_16_32 = 2'b00,
		SCC_RANGE_32_64 = 2'b01,
		SCC_RANGE_ABOVE_64 = 2'b10,
		SCC_RANGE_RESERVED = 2'b11
	} scc_range_e;

	// Divisor of the host clock for the PCI clock output.
	typedef enum logic [1:0] {
		SCC_PCIDIV_RESERVED = 2'b00,
		SCC_PCIDIV_BY4 = 2'b01,
		SCC_PCIDIV_BY3 = 2'b10,
		SCC_PCIDIV_BY2 = 2'b11
	} scc_pcidiv_e;

	// Reset sequencing states.
	typedef enum logic [1:0] {
		SCC_ST_SAMPLE = 2'b00,
		SCC_ST_HOLD = 2'b01,
		SCC_ST_RUN = 2'b10
	} scc_rst_e;

	typedef logic [`SCC_HOLD_CNT_W-1:0] scc_holdcnt_t;
	typedef logic [`SCC_MD_W-1:0] scc_straps_t;
endpackage : scc_pkg

// *** verilog/scc_strap_clock_config.sv ***
// Strap capture and clock configuration registers behind an Avalon-MM slave.
// Notes on behaviour
// (R01) PCI clock range straps in register zero.
// (R02) Sync strap unifies equal memory, host clocks.
// (R03) Two straps pick PCI clock output divisor.
// (R04) Register zero bits 3-2 mirror host speed.
// (R05) Register one is wholly reserved.
// (R06) Dot clock pin direction from bit four.
// (R07) Software may write the dot clock bit.
// (R08) Memory clock output driven or tristated.
// (R09) Host clock pin direction from bit two.
// (R10) Register two resets to captured strap levels.
// (R11) Five straps set host synthesizer speed.
// (R12) Two straps pick host input PLL range.
// (R13) One strap picks core times one or two.
// (R14) Board presents DLL tick straps as 010.
// (R15) Bus strap selects ISA or local bus.
// (R16) Straps resampled while reset input low.
// (R17) Board holds straps until reset output high.
// (R18) Captured values frozen after reset output rises.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
module scc_strap_clock_config (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic systemResetInputN,
	input wire logic [`SCC_MD_W-1:0] memoryDataStrapLines,
	input wire logic clocksSameFreq,
	input wire logic [`SCC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	output logic systemResetOutputN,
	output logic dotClockOeN,
	output logic memoryClockOeN,
	output logic hostClockOeN,
	output scc_pkg::scc_range_e pciClockRange,
	output scc_pkg::scc_pcidiv_e pciClockDivisor,
	output logic unifyClocks,
	output logic [4:0] hostSynthCode,
	output scc_pkg::scc_range_e hostInputRange,
	output logic hostInputPllEn,
	output logic coreTimesTwoMode,
	output logic [2:0] coreDllTick,
	output logic localBusEn,
	output logic isaBusEn
);
	import scc_pkg::*;

	wire logic [`SCC_MD_W:0] syncOut;
	wire logic sysRstInHigh;
	scc_straps_t straps;
	scc_rst_e state_r;
	scc_rst_e state_nxt;
	scc_holdcnt_t holdCnt_r;
	wire logic holdDone, sampling;

	// Stored strap fields.
	scc_range_e pciRange_r;
	logic syncSel_r;
	logic pciDivHi_r, pciDivLo_r;
	logic dotSel_r, memSel_r, hostSel_r;
	logic [4:0] hostSpeed_r;
	scc_range_e hostInRange_r;
	logic coreX2_r;
	logic [2:0] dllTick_r;
	logic busSel_r;

	// Straps and reset input come from pins, so all pass the synchroniser.
	scc_sync3 #(.W(`SCC_MD_W + 1)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.asyncIn({systemResetInputN, memoryDataStrapLines}),
		.stableOut(syncOut)
	);
	assign sysRstInHigh = syncOut[`SCC_MD_W];
	assign straps = syncOut[`SCC_MD_W-1:0];

	// Reset sequencing: sample, hold straps for a while, then run.
	assign holdDone = holdCnt_r == scc_holdcnt_t'(`SCC_RELEASE_CYCLES - 1);
	assign sampling = state_r == SCC_ST_SAMPLE;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SCC_ST_SAMPLE: state_nxt = sysRstInHigh ? SCC_ST_HOLD : SCC_ST_SAMPLE;
			SCC_ST_HOLD: state_nxt = !sysRstInHigh ? SCC_ST_SAMPLE :
				holdDone ? SCC_ST_RUN : SCC_ST_HOLD;
			SCC_ST_RUN: state_nxt = sysRstInHigh ? SCC_ST_RUN : SCC_ST_SAMPLE;
			default: state_nxt = SCC_ST_SAMPLE;
		endcase
	end

	// The hold counter runs only while waiting to release the reset output.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= SCC_ST_SAMPLE;
			holdCnt_r <= '0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			holdCnt_r <= (state_r == SCC_ST_HOLD) ? holdCnt_r + 1'b1 : '0;
		end
	end

	// Avalon decode and handshake terms.
	wire logic [7:0] regIdx;
	wire logic aligned;
	wire logic hitStrap0;
	wire logic hitStrap1;
	wire logic hitStrap2;
	wire logic hitHost;
	wire logic hitStatus;
	wire logic hitAny;
	wire logic reqValid;
	wire logic acceptReq;
	wire logic wrFire;
	wire logic dotWrite;
	logic waitReq_r;
	assign regIdx = avs_address[`SCC_IDX_RANGE];
	assign aligned = avs_address[`SCC_ALIGN_RANGE] == '0;
	assign hitStrap0 = aligned && regIdx == `SCC_IDX_PCI_SYNC;
	assign hitStrap1 = aligned && regIdx == `SCC_IDX_RSVD;
	assign hitStrap2 = aligned && regIdx == `SCC_IDX_PAD_DIR;
	assign hitHost = aligned && regIdx == `SCC_IDX_HOST_SPD;
	assign hitStatus = aligned && regIdx == `SCC_IDX_STATUS;
	assign hitAny = hitStrap0 | hitStrap1 | hitStrap2 | hitHost | hitStatus;
	assign reqValid = avs_read | avs_write;
	assign acceptReq = reqValid & waitReq_r;
	assign wrFire = avs_write & ~waitReq_r;
	assign dotWrite = wrFire && hitStrap2 && avs_byteenable[`SCC_BYTE0_BE];

	// Read words; reserved bits read as zero.
	wire logic [7:0] rdStrap0;
	wire logic [7:0] rdStrap2;
	wire logic [7:0] rdHost;
	wire logic [11:0] rdStatus;
	wire logic [31:0] rdWord;
	assign rdStrap0 = {pciRange_r, syncSel_r, pciDivHi_r, hostSpeed_r[4:3], 2'b00}; // R01 R04
	assign rdStrap2 = {3'b000, dotSel_r, memSel_r, hostSel_r, pciDivLo_r, 1'b0};
	assign rdHost = {hostSpeed_r, 3'b000}; // R11
	assign rdStatus = {unifyClocks, hostInRange_r == SCC_RANGE_RESERVED,
		pciRange_r == SCC_RANGE_RESERVED, {pciDivHi_r, pciDivLo_r} == 2'b00,
		dllTick_r, hostInRange_r, coreX2_r, busSel_r, state_r == SCC_ST_RUN};
	assign rdWord = hitStrap0 ? {24'h000000, rdStrap0} :
		hitStrap2 ? {24'h000000, rdStrap2} :
		hitHost ? {24'h000000, rdHost} :
		hitStatus ? {20'h00000, rdStatus} :
		32'h00000000; // R05

	// One wait cycle per request; the answer then holds until the next request is accepted.
	logic [31:0] rdData_r;
	logic [1:0] resp_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitReq_r <= 1'b1;
			rdData_r <= 32'h00000000;
			resp_r <= `SCC_RESP_OKAY;
		end else if (clkEn) begin
			waitReq_r <= ~acceptReq;
			if (acceptReq) begin
				rdData_r <= avs_read ? rdWord : 32'h00000000;
				resp_r <= hitAny ? `SCC_RESP_OKAY : `SCC_RESP_DECODEERR;
			end
		end
	end

	// Straps are captured every cycle while the reset input is low.
	// After that they hold until the reset input falls again, whatever the board drives.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pciRange_r <= SCC_RANGE_16_32;
			syncSel_r <= 1'b0;
			pciDivHi_r <= 1'b0;
			pciDivLo_r <= 1'b0;
			memSel_r <= 1'b0;
			hostSel_r <= 1'b0;
			hostSpeed_r <= '0;
			hostInRange_r <= SCC_RANGE_16_32;
			coreX2_r <= 1'b0;
			dllTick_r <= '0;
			busSel_r <= 1'b0;
		end else if (clkEn && sampling) begin // R16 R17 R18
			pciRange_r <= scc_range_e'(straps[`SCC_MD_PCI_RANGE]); // R01
			syncSel_r <= straps[`SCC_MD_SYNC]; // R02
			pciDivHi_r <= straps[`SCC_MD_PCI_DIV_HI]; // R03
			pciDivLo_r <= straps[`SCC_MD_PCI_DIV_LO]; // R03 R10
			memSel_r <= straps[`SCC_MD_MEM_PAD]; // R08 R10
			hostSel_r <= straps[`SCC_MD_HOST_PAD]; // R09 R10
			hostSpeed_r <= {straps[`SCC_MD_HOST_SPD_HI], straps[`SCC_MD_HOST_SPD_LO]}; // R11
			hostInRange_r <= scc_range_e'(straps[`SCC_MD_HOST_CLOCK_INPUT_RANGE]); // R12
			coreX2_r <= straps[`SCC_MD_CORE_X2]; // R13
			dllTick_r <= straps[`SCC_MD_DLL_TICK];
			busSel_r <= straps[`SCC_MD_BUS_SEL]; // R15
		end
	end

	// The dot clock bit is the one field software may change after capture.
	// A write during sampling is dropped, as the next capture would undo it.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dotSel_r <= 1'b0;
		end else if (clkEn && sampling) begin
			dotSel_r <= straps[`SCC_MD_DOT_PAD]; // R06 R10 R16
		end else if (clkEn && dotWrite) begin
			dotSel_r <= avs_writedata[`SCC_S2_DOT_BIT]; // R07
		end
	end

	// Output flops: pad enables are low while the pad drives.
	logic sysRstOut_r;
	logic dotOeN_r;
	logic memOeN_r;
	logic hostOeN_r;
	logic unify_r;
	logic localBus_r;
	logic isaBus_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sysRstOut_r <= 1'b0;
			dotOeN_r <= 1'b1;
			memOeN_r <= 1'b1;
			hostOeN_r <= 1'b1;
			unify_r <= 1'b0;
			localBus_r <= 1'b0;
			isaBus_r <= 1'b0;
		end else if (clkEn) begin
			sysRstOut_r <= state_r == SCC_ST_RUN; // R18
			dotOeN_r <= ~dotSel_r; // R06
			memOeN_r <= ~memSel_r; // R08
			hostOeN_r <= ~hostSel_r; // R09
			unify_r <= syncSel_r & clocksSameFreq; // R02
			localBus_r <= busSel_r; // R15
			isaBus_r <= ~busSel_r; // R15
		end
	end

	// Clock configuration output flops.
	scc_range_e pciRangeOut_r;
	scc_pcidiv_e pciDivOut_r;
	logic [4:0] synthOut_r;
	scc_range_e hostRangeOut_r;
	logic hostPllEn_r;
	logic coreX2Out_r;
	logic [2:0] dllOut_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pciRangeOut_r <= SCC_RANGE_16_32;
			pciDivOut_r <= SCC_PCIDIV_RESERVED;
			synthOut_r <= '0;
			hostRangeOut_r <= SCC_RANGE_16_32;
			hostPllEn_r <= 1'b0;
			coreX2Out_r <= 1'b0;
			dllOut_r <= '0;
		end else if (clkEn) begin
			pciRangeOut_r <= pciRange_r; // R01
			pciDivOut_r <= scc_pcidiv_e'({pciDivHi_r, pciDivLo_r}); // R03
			synthOut_r <= hostSpeed_r; // R11
			hostRangeOut_r <= hostInRange_r; // R12
			hostPllEn_r <= hostInRange_r != `SCC_RESERVED_CODE; // R12
			coreX2Out_r <= coreX2_r; // R13
			dllOut_r <= dllTick_r;
		end
	end

	assign avs_readdata = rdData_r;
	assign avs_waitrequest = waitReq_r;
	assign avs_response = resp_r;
	assign systemResetOutputN = sysRstOut_r;
	assign dotClockOeN = dotOeN_r;
	assign memoryClockOeN = memOeN_r;
	assign hostClockOeN = hostOeN_r;
	assign pciClockRange = pciRangeOut_r;
	assign pciClockDivisor = pciDivOut_r;
	assign unifyClocks = unify_r;
	assign hostSynthCode = synthOut_r;
	assign hostInputRange = hostRangeOut_r;
	assign hostInputPllEn = hostPllEn_r;
	assign coreTimesTwoMode = coreX2Out_r;
	assign coreDllTick = dllOut_r;
	assign localBusEn = localBus_r;
	assign isaBusEn = isaBus_r;

	// Checks on the captured values and the pads they steer.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_sample_pci_range: assert property (clkEn && sampling |=> // R16
		pciRange_r == $past(straps[`SCC_MD_PCI_RANGE]))
		else $error("PCI range not sampled during reset.");
	a_frozen_after_release: assert property (clkEn && !sampling && $past(!sampling) |-> // R18
		$stable(hostSpeed_r) && $stable(busSel_r) && $stable(pciRange_r))
		else $error("Straps changed after capture.");
	a_dot_pad_dir: assert property (clkEn |=> dotClockOeN == !$past(dotSel_r)) // R06
		else $error("Dot clock pad enable wrong.");
	a_mem_pad_dir: assert property (clkEn |=> memoryClockOeN == !$past(memSel_r)) // R08
		else $error("Memory clock pad enable wrong.");
	a_host_pad_dir: assert property (clkEn |=> hostClockOeN == !$past(hostSel_r)) // R09
		else $error("Host clock pad enable wrong.");
	a_pci_divisor: assert property (clkEn |=> // R03
		pciClockDivisor == {$past(pciDivHi_r), $past(pciDivLo_r)})
		else $error("PCI divisor mismatch.");
	a_unify_clocks: assert property (clkEn |=> unifyClocks == ($past(syncSel_r) && $past(clocksSameFreq))) // R02
		else $error("Clock unify wrong.");
	a_bus_exclusive: assert property (clkEn && reset_n |=> localBusEn != isaBusEn) // R15
		else $error("Both or neither bus enabled.");
	a_core_mode: assert property (clkEn |=> coreTimesTwoMode == $past(coreX2_r)) // R13
		else $error("Core mode wrong.");
	a_host_range: assert property (clkEn && reset_n |=> // R12
		hostInputPllEn == ($past(hostInRange_r) != SCC_RANGE_RESERVED))
		else $error("Host PLL enable wrong.");
	a_rsvd_reads_zero: assert property (clkEn && acceptReq && avs_read && hitStrap1 |=> // R05
		avs_readdata == 32'h00000000 && !avs_waitrequest)
		else $error("Reserved register read nonzero.");
	a_mirror_speed: assert property (clkEn && acceptReq && avs_read && hitStrap0 |=> // R04
		avs_readdata[3:2] == $past(hostSpeed_r[4:3])) else $error("Speed mirror mismatch.");
	a_dot_write: assert property (clkEn && dotWrite && !sampling |=> // R07
		dotSel_r == $past(avs_writedata[`SCC_S2_DOT_BIT]))
		else $error("Dot clock write lost.");
	a_synth_code: assert property (clkEn |=> hostSynthCode == $past(hostSpeed_r)) // R11
		else $error("Synth code wrong.");
	a_release_delay: assert property (state_r == SCC_ST_HOLD && holdDone && clkEn && // R18
		sysRstInHigh |=> ##1 systemResetOutputN)
		else $error("Reset output not released.");

	c_release: cover property (state_r == SCC_ST_HOLD ##1 state_r == SCC_ST_RUN);
	c_dot_write: cover property (dotWrite && !sampling);
	c_unmapped: cover property (acceptReq && !hitAny);
	c_resample: cover property (state_r == SCC_ST_RUN ##1 state_r == SCC_ST_SAMPLE);
endmodule : scc_strap_clock_config
`default_nettype wire

// *** verilog/scc_sync3.sv ***
// Three-stage synchroniser that accepts a bit once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module scc_sync3 #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] stableOut
);
	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	logic [W-1:0] stable_r;
	wire logic [W-1:0] agree;
	wire logic [W-1:0] stable_nxt;

	// Stage one feeds only stage two, so no logic sees a metastable level.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			stable_r <= '0;
		end else if (clkEn) begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			stable_r <= stable_nxt;
		end
	end

	// A bit changes only after two stages have seen the same level.
	assign agree = ~(stage2_r ^ stage3_r);
	assign stable_nxt = (stage2_r & agree) | (stable_r & ~agree);
	assign stableOut = stable_r;
endmodule : scc_sync3
`default_nettype wire
